/* rtl/wrf_chan.sv */
// one wake channel: pin synchroniser, trigger detect, request and edge record
`timescale 1ns/100ps
`default_nettype none
module wrf_chan (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic line_i,
  input wire logic [2:0] trig_i,
  input wire logic en_i,
  input wire logic clr_i,
  output logic req_o,
  output logic [1:0] seen_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic req;
    logic [1:0] seen;
  } wrf_chan_st_t;

  localparam wrf_chan_st_t CHAN_RST = '0;

  wrf_chan_st_t st_ff;
  wrf_chan_st_t nxt_st;
  logic rise;
  logic fall;
  logic hit;

  always_comb begin
    nxt_st = st_ff;
    rise = st_ff.sync2 & ~st_ff.prev;
    fall = ~st_ff.sync2 & st_ff.prev;
    case (trig_i)
      wrf_pkg::TRIG_LOW: hit = ~st_ff.sync2;
      wrf_pkg::TRIG_HIGH: hit = st_ff.sync2;
      wrf_pkg::TRIG_FALL: hit = fall;
      wrf_pkg::TRIG_RISE: hit = rise;
      wrf_pkg::TRIG_BOTH: hit = rise | fall;
      // prohibited codes never fire
      default: hit = 1'b0;
    endcase
    nxt_st.sync1 = line_i;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    if (clr_i) begin
      nxt_st.req = 1'b0;
      nxt_st.seen = wrf_pkg::SEEN_NONE;
    end
    // a new hit in the clear cycle wins
    if (en_i && hit) begin
      nxt_st.req = 1'b1;
      if (trig_i == wrf_pkg::TRIG_BOTH) begin
        nxt_st.seen = nxt_st.seen | {fall, rise};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_ff <= CHAN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req_o = st_ff.req;
  assign seen_o = st_ff.seen;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_rise_armed;
    en_i && trig_i == wrf_pkg::TRIG_RISE && rise;
  endsequence

  a_req_hold: assert property (st_ff.req && !clr_i |=> st_ff.req)
    else $error("request dropped without a clear");
  a_seen_clear: assert property (clr_i && !(en_i && hit) |=> st_ff.seen == wrf_pkg::SEEN_NONE)
    else $error("edge record survived a clear");
  a_rise_fire: assert property (s_rise_armed |=> st_ff.req)
    else $error("rising edge did not raise request");
  a_both_rec: assert property (en_i && trig_i == wrf_pkg::TRIG_BOTH && fall && !clr_i
    |=> st_ff.seen[1])
    else $error("falling edge not recorded");
  a_en_gate: assert property (!en_i && !st_ff.req |=> !st_ff.req)
    else $error("disabled channel raised request");
  a_seen_mode: assert property (trig_i != wrf_pkg::TRIG_BOTH && st_ff.seen == wrf_pkg::SEEN_NONE
    |=> st_ff.seen == wrf_pkg::SEEN_NONE)
    else $error("edge record set outside both-edge mode");
endmodule : wrf_chan
`default_nettype wire

/* rtl/wrf_pkg.sv */
// constants for the wake request and reset cause flag block
package wrf_pkg;
  localparam logic [7:0] OFS_WAKE_CFG = 8'h00;
  localparam logic [7:0] OFS_WAKE_CLR = 8'h04;
  localparam logic [7:0] OFS_NMI_FLAGS = 8'h08;
  localparam logic [7:0] OFS_RST_FLAGS = 8'h0C;
  localparam int NUM_CH = 3;
  localparam int CH_STRIDE = 8;
  localparam int EN_POS = 0;
  localparam int SEEN_LSB = 2;
  localparam int TRIG_LSB = 4;
  localparam logic [2:0] TRIG_LOW = 3'h0;
  localparam logic [2:0] TRIG_HIGH = 3'h1;
  localparam logic [2:0] TRIG_FALL = 3'h2;
  localparam logic [2:0] TRIG_RISE = 3'h3;
  localparam logic [2:0] TRIG_BOTH = 3'h4;
  localparam logic [2:0] TRIG_RST = TRIG_FALL;
  localparam logic EN_RST = 1'b0;
  localparam logic [1:0] SEEN_NONE = 2'h0;
  localparam logic [1:0] SEEN_RISE = 2'h1;
  localparam logic [1:0] SEEN_FALL = 2'h2;
  localparam int CLR_W = 5;
  localparam logic [4:0] CLR_CODE_A = 5'h00;
  localparam logic [4:0] CLR_CODE_C = 5'h02;
  localparam int NMI_WDT_POS = 0;
  localparam int RF_W = 6;
  localparam int RF_PON = 0;
  localparam int RF_PIN = 1;
  localparam int RF_WDT = 2;
  localparam int RF_VOLTAGE_DETECTOR = 3;
  localparam int RF_SYSREQ = 4;
  localparam int RF_FREQ = 5;
  localparam logic [5:0] RF_POR_VAL = 6'h01;
  localparam int CS_PIN = 0;
  localparam int CS_WDT = 1;
  localparam int CS_VOLTAGE_DETECTOR = 2;
  localparam int CS_FREQ = 3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : wrf_pkg

/* rtl/wrf_top.sv */
// wake request channels, nmi cause flag and reset cause flags
//
// What this block does
// - trigger code picks low, high, falling, rising or both edges; 101-111 never fire
// - trigger fields sit at bits 22-20, 14-12 and 6-4
// - read-only 2-bit edge record, rise 01, fall 10, valid in both-edge mode
// - clearing a request by command also empties its edge record
// - per-channel enable at bits 16, 8 and 0 gates request raising
// - 5-bit clear command codes 0, 1, 2 pick a channel; reads back zero
// - nmi cause bit 0 is set when the watchdog raises the nmi
// - reading the nmi cause register returns the flag and then clears it
// - reset cause register initialised only by power-on, which sets bit 0
// - cause bits 5 to 1 are set by their reset sources
// - cpu system reset request triggers a warm reset that follows the request one cycle later and drops one cycle after it drops
`timescale 1ns/100ps
`default_nettype none
module wrf_top (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ext_line_a_i,
  input wire logic ext_line_b_i,
  input wire logic ext_line_c_i,
  input wire logic watchdog_nmi_i,
  input wire logic pin_rst_i,
  input wire logic watchdog_rst_i,
  input wire logic voltage_detect_rst_i,
  input wire logic freq_detect_rst_i,
  input wire logic cpu_system_reset_request_i,
  output logic [2:0] wake_req_o,
  output logic wake_any_o,
  output logic warm_reset_o
);
  typedef struct packed {
    logic [2:0][2:0] trig;
    logic [2:0] en;
    logic nmi;
    logic [5:0] rstf;
    logic [3:0] cause_s1;
    logic [3:0] cause_s2;
    logic warm;
    logic [31:0] rdata;
  } wrf_top_st_t;

  // power-on value: the only place the cause register gets its start value
  localparam wrf_top_st_t TOP_POR = '{
    trig: {3{wrf_pkg::TRIG_RST}},
    en: {3{wrf_pkg::EN_RST}},
    nmi: 1'b0,
    rstf: wrf_pkg::RF_POR_VAL,
    cause_s1: 4'h0,
    cause_s2: 4'h0,
    warm: 1'b0,
    rdata: wrf_pkg::RD_ZERO
  };

  wrf_top_st_t st_ff;
  wrf_top_st_t nxt_st;
  logic [2:0] lines;
  logic [2:0] clr_hit;
  logic [2:0] req;
  logic [2:0][1:0] seen;
  logic chan_rst;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hits

  // one channel's byte of the config register
  function automatic logic [7:0] pack_chan(input logic [2:0] t, input logic [1:0] e, input logic n);
    logic [7:0] f;
    f = 8'h00;
    f[wrf_pkg::EN_POS] = n;
    f[wrf_pkg::SEEN_LSB +: 2] = e;
    f[wrf_pkg::TRIG_LSB +: 3] = t;
    return f;
  endfunction : pack_chan

  assign lines = {ext_line_c_i, ext_line_b_i, ext_line_a_i};
  assign chan_rst = reset_i | por_i;

  genvar g;
  generate
    for (g = 0; g < wrf_pkg::NUM_CH; g++) begin : g_ch
      // only codes 0..2 reach a channel; the rest are ignored
      assign clr_hit[g] = wr_i && hits(addr_i, wrf_pkg::OFS_WAKE_CLR)
        && wdata_i[wrf_pkg::CLR_W-1:0] == wrf_pkg::CLR_CODE_A + 5'(g);
      wrf_chan u_chan (
        .mclk_i(mclk_i),
        .reset_i(chan_rst),
        .line_i(lines[g]),
        .trig_i(st_ff.trig[g]),
        .en_i(st_ff.en[g]),
        .clr_i(clr_hit[g]),
        .req_o(req[g]),
        .seen_o(seen[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    // two-stage synchronisers for the asynchronous reset causes
    nxt_st.cause_s1[wrf_pkg::CS_PIN] = pin_rst_i;
    nxt_st.cause_s1[wrf_pkg::CS_WDT] = watchdog_rst_i;
    nxt_st.cause_s1[wrf_pkg::CS_VOLTAGE_DETECTOR] = voltage_detect_rst_i;
    nxt_st.cause_s1[wrf_pkg::CS_FREQ] = freq_detect_rst_i;
    nxt_st.cause_s2 = st_ff.cause_s1;
    // the cpu keeps its request up until our warm reset lands
    nxt_st.warm = cpu_system_reset_request_i;

    // trigger and enable are stored as written; ordering is software's job
    if (wr_i && hits(addr_i, wrf_pkg::OFS_WAKE_CFG)) begin
      for (int k = 0; k < wrf_pkg::NUM_CH; k++) begin
        nxt_st.trig[k] = wdata_i[k*wrf_pkg::CH_STRIDE + wrf_pkg::TRIG_LSB +: 3];
        nxt_st.en[k] = wdata_i[k*wrf_pkg::CH_STRIDE + wrf_pkg::EN_POS];
      end
    end

    if (rd_i && hits(addr_i, wrf_pkg::OFS_NMI_FLAGS)) begin
      nxt_st.nmi = 1'b0;
    end
    // a watchdog nmi in the read cycle survives the read
    if (watchdog_nmi_i) begin
      nxt_st.nmi = 1'b1;
    end

    // a written zero clears, a written one leaves the bit alone
    if (wr_i && hits(addr_i, wrf_pkg::OFS_RST_FLAGS)) begin
      nxt_st.rstf = st_ff.rstf & wdata_i[wrf_pkg::RF_W-1:0];
    end
    if (st_ff.cause_s2[wrf_pkg::CS_PIN]) begin
      nxt_st.rstf[wrf_pkg::RF_PIN] = 1'b1;
    end
    if (st_ff.cause_s2[wrf_pkg::CS_WDT]) begin
      nxt_st.rstf[wrf_pkg::RF_WDT] = 1'b1;
    end
    if (st_ff.cause_s2[wrf_pkg::CS_VOLTAGE_DETECTOR]) begin
      nxt_st.rstf[wrf_pkg::RF_VOLTAGE_DETECTOR] = 1'b1;
    end
    if (st_ff.cause_s2[wrf_pkg::CS_FREQ]) begin
      nxt_st.rstf[wrf_pkg::RF_FREQ] = 1'b1;
    end
    if (cpu_system_reset_request_i) begin
      nxt_st.rstf[wrf_pkg::RF_SYSREQ] = 1'b1;
    end

    // read data stands only in the cycle after the strobe
    nxt_st.rdata = wrf_pkg::RD_ZERO;
    if (rd_i) begin
      case (addr_i)
        wrf_pkg::OFS_WAKE_CFG: begin
          for (int k = 0; k < wrf_pkg::NUM_CH; k++) begin
            nxt_st.rdata[k*wrf_pkg::CH_STRIDE +: 8] = pack_chan(st_ff.trig[k], seen[k], st_ff.en[k]);
          end
        end
        wrf_pkg::OFS_WAKE_CLR: nxt_st.rdata = wrf_pkg::RD_ZERO;
        wrf_pkg::OFS_NMI_FLAGS: nxt_st.rdata[wrf_pkg::NMI_WDT_POS] = st_ff.nmi;
        wrf_pkg::OFS_RST_FLAGS: nxt_st.rdata[wrf_pkg::RF_W-1:0] = st_ff.rstf;
        default: nxt_st.rdata = wrf_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      st_ff <= TOP_POR;
    end else begin
      // warm reset keeps cause flags and their synchronisers running
      st_ff <= nxt_st;
      if (reset_i) begin
        st_ff.trig <= TOP_POR.trig;
        st_ff.en <= TOP_POR.en;
        st_ff.nmi <= TOP_POR.nmi;
        st_ff.rdata <= TOP_POR.rdata;
      end
    end
  end

  assign rdata_o = st_ff.rdata;
  assign wake_req_o = req;
  // or of channel flops, no extra gating
  assign wake_any_o = |req;
  assign warm_reset_o = st_ff.warm;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i || por_i);

  sequence s_nmi_read;
    rd_i && hits(addr_i, wrf_pkg::OFS_NMI_FLAGS) && !watchdog_nmi_i;
  endsequence

  sequence s_sysreq;
    cpu_system_reset_request_i;
  endsequence

  sequence s_rst_write;
    wr_i && hits(addr_i, wrf_pkg::OFS_RST_FLAGS);
  endsequence

  sequence s_rst_read;
    rd_i && hits(addr_i, wrf_pkg::OFS_RST_FLAGS);
  endsequence

  sequence s_cfg_write;
    wr_i && hits(addr_i, wrf_pkg::OFS_WAKE_CFG);
  endsequence

  sequence s_cfg_read;
    rd_i && hits(addr_i, wrf_pkg::OFS_WAKE_CFG);
  endsequence

  sequence s_clr_write;
    wr_i && hits(addr_i, wrf_pkg::OFS_WAKE_CLR);
  endsequence

  a_nmi_set: assert property (watchdog_nmi_i |=> st_ff.nmi ##1 (st_ff.nmi || $past(rd_i)))
    else $error("watchdog nmi not recorded");

  a_nmi_rdclr: assert property (s_nmi_read |=> !st_ff.nmi && rdata_o[0] == $past(st_ff.nmi))
    else $error("nmi flag not returned and cleared by read");

  a_nmi_quiet: assert property (!watchdog_nmi_i && !st_ff.nmi |=> !st_ff.nmi)
    else $error("nmi flag set without a watchdog nmi");

  a_nmi_keep: assert property (st_ff.nmi && !(rd_i && hits(addr_i, wrf_pkg::OFS_NMI_FLAGS)) |=> st_ff.nmi)
    else $error("nmi flag dropped without a read");

  a_rd_idle: assert property (!rd_i |=> rdata_o == wrf_pkg::RD_ZERO)
    else $error("read data present without a read");

  a_clr_reads: assert property (rd_i && hits(addr_i, wrf_pkg::OFS_WAKE_CLR)
    |=> rdata_o == wrf_pkg::RD_ZERO)
    else $error("clear command register read nonzero");

  a_clr_reserved: assert property (wr_i && wdata_i[wrf_pkg::CLR_W-1:0] > wrf_pkg::CLR_CODE_C
    |-> clr_hit == 3'h0)
    else $error("reserved clear code cleared a channel");

  a_clr_route_a: assert property (s_clr_write and wdata_i[wrf_pkg::CLR_W-1:0] == wrf_pkg::CLR_CODE_A
    |-> clr_hit == 3'h1)
    else $error("first clear code missed its channel");

  a_clr_route_c: assert property (s_clr_write and wdata_i[wrf_pkg::CLR_W-1:0] == wrf_pkg::CLR_CODE_C
    |-> clr_hit == 3'h4)
    else $error("third clear code missed its channel");

  a_clr_addr: assert property (!(wr_i && hits(addr_i, wrf_pkg::OFS_WAKE_CLR)) |-> clr_hit == 3'h0)
    else $error("channel cleared without a clear command");

  // the looped-back warm reset must not mask these checks
  a_sysreq_warm: assert property (@(posedge mclk_i) disable iff (por_i) s_sysreq
    |=> warm_reset_o && st_ff.rstf[wrf_pkg::RF_SYSREQ])
    else $error("system reset request not turned into warm reset");

  a_warm_drop: assert property (@(posedge mclk_i) disable iff (por_i) !cpu_system_reset_request_i
    |=> !warm_reset_o)
    else $error("warm reset outlived the cpu request");

  a_rf_noauto: assert property (@(posedge mclk_i) disable iff (por_i)
    !(wr_i && hits(addr_i, wrf_pkg::OFS_RST_FLAGS))
    |=> (st_ff.rstf & $past(st_ff.rstf)) == $past(st_ff.rstf))
    else $error("reset cause flag dropped without a write");

  a_pon_only: assert property (@(posedge mclk_i) disable iff (por_i)
    !(wr_i && hits(addr_i, wrf_pkg::OFS_RST_FLAGS)) |=> $stable(st_ff.rstf[wrf_pkg::RF_PON]))
    else $error("power-on flag changed after power-on");

  a_rf_wrclr: assert property (s_rst_write and (!wdata_i[wrf_pkg::RF_PIN]
    && !st_ff.cause_s2[wrf_pkg::CS_PIN]) |=> !st_ff.rstf[wrf_pkg::RF_PIN])
    else $error("written zero did not clear cause flag");

  a_rf_read: assert property (s_rst_read |=> rdata_o[wrf_pkg::RF_W-1:0] == $past(st_ff.rstf)
    && rdata_o[31:wrf_pkg::RF_W] == '0)
    else $error("cause flags read back wrong");

  a_por_init: assert property (@(posedge mclk_i) por_i |=> st_ff.rstf == wrf_pkg::RF_POR_VAL)
    else $error("power-on did not initialise cause flags");

  a_cause_set: assert property (@(posedge mclk_i) disable iff (por_i) watchdog_rst_i
    |-> ##3 st_ff.rstf[wrf_pkg::RF_WDT])
    else $error("watchdog reset cause not flagged");

  a_cause_pin: assert property (@(posedge mclk_i) disable iff (por_i) pin_rst_i
    |-> ##3 st_ff.rstf[wrf_pkg::RF_PIN])
    else $error("pin reset cause not flagged");

  a_cause_voltage_detector: assert property (@(posedge mclk_i) disable iff (por_i) voltage_detect_rst_i
    |-> ##3 st_ff.rstf[wrf_pkg::RF_VOLTAGE_DETECTOR])
    else $error("voltage detect reset cause not flagged");

  a_cause_freq: assert property (@(posedge mclk_i) disable iff (por_i) freq_detect_rst_i
    |-> ##3 st_ff.rstf[wrf_pkg::RF_FREQ])
    else $error("frequency detect reset cause not flagged");

  a_cfg_reset: assert property (@(posedge mclk_i) disable iff (por_i) reset_i
    |=> st_ff.trig == TOP_POR.trig && st_ff.en == TOP_POR.en)
    else $error("trigger config not at reset value");

  a_cfg_write: assert property (s_cfg_write |=> st_ff.trig[0] == $past(wdata_i[wrf_pkg::TRIG_LSB +: 3])
    && st_ff.trig[1] == $past(wdata_i[wrf_pkg::CH_STRIDE + wrf_pkg::TRIG_LSB +: 3])
    && st_ff.trig[2] == $past(wdata_i[2*wrf_pkg::CH_STRIDE + wrf_pkg::TRIG_LSB +: 3]))
    else $error("trigger fields not taken from their bit positions");

  a_en_write: assert property (s_cfg_write |=> st_ff.en[0] == $past(wdata_i[wrf_pkg::EN_POS])
    && st_ff.en[1] == $past(wdata_i[wrf_pkg::CH_STRIDE + wrf_pkg::EN_POS])
    && st_ff.en[2] == $past(wdata_i[2*wrf_pkg::CH_STRIDE + wrf_pkg::EN_POS]))
    else $error("enable bits not taken from their bit positions");

  a_cfg_keep: assert property (!(wr_i && hits(addr_i, wrf_pkg::OFS_WAKE_CFG))
    |=> $stable(st_ff.trig) && $stable(st_ff.en))
    else $error("trigger config changed without a write");

  a_cfg_read: assert property (s_cfg_read
    |=> rdata_o[2*wrf_pkg::CH_STRIDE + wrf_pkg::TRIG_LSB +: 3] == $past(st_ff.trig[2])
    && rdata_o[2*wrf_pkg::CH_STRIDE + 1] == 1'b0)
    else $error("config readback misplaced");

  a_cfg_rd_ab: assert property (s_cfg_read
    |=> rdata_o[wrf_pkg::TRIG_LSB +: 3] == $past(st_ff.trig[0])
    && rdata_o[wrf_pkg::CH_STRIDE + wrf_pkg::TRIG_LSB +: 3] == $past(st_ff.trig[1]))
    else $error("first or second trigger field read back misplaced");

  a_en_read: assert property (s_cfg_read
    |=> rdata_o[wrf_pkg::EN_POS] == $past(st_ff.en[0])
    && rdata_o[wrf_pkg::CH_STRIDE + wrf_pkg::EN_POS] == $past(st_ff.en[1])
    && rdata_o[2*wrf_pkg::CH_STRIDE + wrf_pkg::EN_POS] == $past(st_ff.en[2]))
    else $error("enable bits read back misplaced");

  a_seen_read: assert property (s_cfg_read
    |=> rdata_o[wrf_pkg::SEEN_LSB +: 2] == $past(seen[0])
    && rdata_o[wrf_pkg::CH_STRIDE + wrf_pkg::SEEN_LSB +: 2] == $past(seen[1])
    && rdata_o[2*wrf_pkg::CH_STRIDE + wrf_pkg::SEEN_LSB +: 2] == $past(seen[2]))
    else $error("edge records read back misplaced");

  a_cfg_spare: assert property (s_cfg_read |=> rdata_o[31:23] == 9'h000 && !rdata_o[15] && !rdata_o[7])
    else $error("unused config bits read nonzero");
endmodule : wrf_top
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the wake request and reset cause block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic mclk_i = 1'b0;
  logic tb_rst = 1'b1;
  logic por_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [3:0] cause = 4'h0;
  logic cpu_req = 1'b0;
  logic wdog_nmi = 1'b0;
  wire logic reset_i;
  wire logic [31:0] rdata_o;
  wire logic [2:0] line;
  wire logic [3:0] cause_o;
  wire logic [2:0] wake_req_o;
  wire logic wake_any_o;
  wire logic warm_reset_o;
  logic [31:0] rd_val;
  logic [31:0] cfg;
  logic [31:0] exp_val;
  logic o, n, en, hit;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 19641;
  int cyc = 0;
  always #5 mclk_i = ~mclk_i;
  // warm reset request loops back as the block's own reset
  assign reset_i = tb_rst | warm_reset_o;
  wrf_pin_model wrf_pin_model_inst (.mclk_i(mclk_i), .lvl_i(lvl), .cause_i(cause), .line_o(line),
    .cause_o(cause_o));
  wrf_top wrf_top_inst (.mclk_i(mclk_i), .reset_i(reset_i), .por_i(por_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_line_a_i(line[0]),
    .ext_line_b_i(line[1]), .ext_line_c_i(line[2]), .watchdog_nmi_i(wdog_nmi),
    .pin_rst_i(cause_o[wrf_pkg::CS_PIN]), .watchdog_rst_i(cause_o[wrf_pkg::CS_WDT]),
    .voltage_detect_rst_i(cause_o[wrf_pkg::CS_VOLTAGE_DETECTOR]), .freq_detect_rst_i(cause_o[wrf_pkg::CS_FREQ]),
    .cpu_system_reset_request_i(cpu_req), .wake_req_o(wake_req_o), .wake_any_o(wake_any_o),
    .warm_reset_o(warm_reset_o));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] rst_cfg();
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int c = 0; c < wrf_pkg::NUM_CH; c++) v |= 32'(wrf_pkg::TRIG_RST) << (c * 8 + wrf_pkg::TRIG_LSB);
    return v;
  endfunction : rst_cfg
  function automatic logic fires(input int m, input logic a, input logic b);
    case (m)
      0: return !a || !b;
      1: return a || b;
      2: return a && !b;
      3: return !a && b;
      4: return a != b;
      default: return 1'b0;
    endcase
  endfunction : fires
  function automatic int cpos(input int i);
    case (i)
      wrf_pkg::CS_PIN: return wrf_pkg::RF_PIN;
      wrf_pkg::CS_WDT: return wrf_pkg::RF_WDT;
      wrf_pkg::CS_VOLTAGE_DETECTOR: return wrf_pkg::RF_VOLTAGE_DETECTOR;
      default: return wrf_pkg::RF_FREQ;
    endcase
  endfunction : cpos
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    tb_rst <= 1'b0;
    por_i <= 1'b0;
    rd(wrf_pkg::OFS_WAKE_CFG); `CHK(rd_val, rst_cfg())
    rd(wrf_pkg::OFS_RST_FLAGS); `CHK(rd_val, 32'h0000_0001)
    rd(8'h44); `CHK(rd_val, 32'h0000_0000)
    @(posedge mclk_i) wdog_nmi <= 1'b1;
    @(posedge mclk_i) wdog_nmi <= 1'b0;
    rd(wrf_pkg::OFS_NMI_FLAGS); `CHK(rd_val, 32'h0000_0001)
    rd(wrf_pkg::OFS_NMI_FLAGS); `CHK(rd_val, 32'h0000_0000)
    wr(wrf_pkg::OFS_RST_FLAGS, 32'h0000_0000);
    exp_val = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i) cause <= 4'(1 << i);
      repeat (4) @(posedge mclk_i);
      cause <= 4'h0;
      repeat (4) @(posedge mclk_i);
      exp_val |= 32'(1) << cpos(i);
      rd(wrf_pkg::OFS_RST_FLAGS); `CHK(rd_val, exp_val)
    end
    wr(wrf_pkg::OFS_RST_FLAGS, 32'hFFFF_FFFF);
    rd(wrf_pkg::OFS_RST_FLAGS); `CHK(rd_val, exp_val)
    wr(wrf_pkg::OFS_RST_FLAGS, 32'h0000_0000);
    rd(wrf_pkg::OFS_RST_FLAGS); `CHK(rd_val, 32'h0000_0000)
    for (int c = 0; c < wrf_pkg::NUM_CH; c++) begin
      for (int m = 0; m < 8; m++) begin
        o = 1'($random(seed));
        n = 1'($random(seed));
        en = (($random(seed) & 3) != 0);
        hit = en && fires(m, o, n);
        @(posedge mclk_i) lvl[c] <= o;
        cfg = 32'(m) << (c * 8 + wrf_pkg::TRIG_LSB);
        // trigger settles before the enable goes in
        wr(wrf_pkg::OFS_WAKE_CFG, cfg);
        repeat (4) @(posedge mclk_i);
        wr(wrf_pkg::OFS_WAKE_CFG, cfg | (32'(en) << (c * 8 + wrf_pkg::EN_POS)));
        repeat (3) @(posedge mclk_i);
        lvl[c] <= n;
        repeat (6) @(posedge mclk_i);
        #1 `CHK(wake_req_o[c], hit)
        `CHK(wake_any_o, hit)
        exp_val = cfg | (32'(en) << (c * 8));
        if (en && m == 4 && o != n) exp_val |= 32'(n ? wrf_pkg::SEEN_RISE : wrf_pkg::SEEN_FALL) << (c * 8 + 2);
        rd(wrf_pkg::OFS_WAKE_CFG); `CHK(rd_val, exp_val)
        wr(wrf_pkg::OFS_WAKE_CLR, 32'(3 + ({$random(seed)} % 29)));
        rd(wrf_pkg::OFS_WAKE_CLR); `CHK(rd_val, 32'h0000_0000)
        `CHK(wake_req_o[c], hit)
        wr(wrf_pkg::OFS_WAKE_CFG, cfg);
        wr(wrf_pkg::OFS_WAKE_CLR, 32'(c));
        @(posedge mclk_i);
        #1 `CHK(wake_req_o[c], 1'b0)
        rd(wrf_pkg::OFS_WAKE_CFG); `CHK(rd_val, cfg)
      end
    end
    wr(wrf_pkg::OFS_WAKE_CFG, 32'h0030_3030);
    @(posedge mclk_i) cpu_req <= 1'b1;
    @(posedge mclk_i);
    #1 `CHK(warm_reset_o, 1'b1)
    @(posedge mclk_i) cpu_req <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(wrf_pkg::OFS_WAKE_CFG); `CHK(rd_val, rst_cfg())
    rd(wrf_pkg::OFS_RST_FLAGS); `CHK(rd_val, 32'(1) << wrf_pkg::RF_SYSREQ)
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire

/* tb/wrf_pin_model.sv */
// external wake pins and reset cause sources facing the wake block
`timescale 1ns/100ps
`default_nettype none
module wrf_pin_model (
  input wire logic mclk_i,
  input wire logic [2:0] lvl_i,
  input wire logic [3:0] cause_i,
  output logic [2:0] line_o,
  output logic [3:0] cause_o
);
  // pins move on the falling edge, away from the block's sampling edge
  always @(negedge mclk_i) begin
    line_o <= lvl_i;
    // bench holds each cause for four clocks so the two-flop sync sees it
    cause_o <= cause_i;
  end
endmodule : wrf_pin_model
`default_nettype wire
